// File: design/psrc_masked_reg.sv
// One software reset register with capability and field masked writes
`timescale 1ns/1ps
module psrc_masked_reg
    import psrc_pkg::*;
#(
    parameter psrc_word_t RW_MASK = 32'h00000000,
    parameter psrc_word_t RST_VAL = 32'h00000000
)(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              wr_en,
    input  wire psrc_pkg::psrc_word_t wr_data,
    input  wire psrc_pkg::psrc_word_t cap_mask,
    output psrc_pkg::psrc_word_t   value
);
    typedef struct packed {
        psrc_word_t bits;
    } psrc_mreg_s;

    psrc_mreg_s state;
    psrc_mreg_s next_state;
    psrc_word_t allow;

    initial
    begin
        if ((RST_VAL & ~RW_MASK) != 32'h00000000)
            $error("reset value sets read-only bits");
    end

    // Bits outside the capability mask keep their old value
    assign allow = RW_MASK & cap_mask;

    always_comb
    begin
        next_state = state;
        if (wr_en)
            next_state.bits = (state.bits & ~allow) | (wr_data & allow);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state <= '{bits: RST_VAL};
        else
            state <= next_state;
    end

    assign value = state.bits;

    property p_masked_hold;
        @(posedge hclk) disable iff (!hresetn)
        wr_en |=> ((value & ~$past(allow)) == ($past(value) & ~$past(allow)));
    endproperty
    a_masked_hold: assert property (p_masked_hold) else $error("masked bit changed on write");
endmodule // psrc_masked_reg

// File: design/psrc_pkg.sv
// Types shared by the peripheral reset control files
package psrc_pkg;
    typedef logic [31:0] psrc_word_t;
    typedef enum logic [1:0] {
        PSRC_SEL_NONE,
        PSRC_SEL_GROUP0,
        PSRC_SEL_GROUP1,
        PSRC_SEL_CAP
    } psrc_sel_e;
endpackage

// File: design/psrc_regs.svh
// Register offsets, field positions and reset values of the peripheral reset control
`ifndef PSRC_REGS_SVH
`define PSRC_REGS_SVH
`define PSRC_GROUP0_OFFSET      12'h040
`define PSRC_GROUP1_OFFSET      12'h044
`define PSRC_CAP_ONE_OFFSET     12'h080
`define PSRC_CAP_TWO_OFFSET     12'h084
`define PSRC_GROUP0_RESET       32'h00000000
`define PSRC_GROUP1_RESET       32'h00000000
`define PSRC_CAP_ONE_RESET      32'h00100008
`define PSRC_CAP_TWO_RESET      32'h07070011
`define PSRC_PWM_BIT            20
`define PSRC_WATCHDOG_BIT       3
`define PSRC_COMPARATOR_TWO_RESET_BIT_BIT          26
`define PSRC_COMPARATOR_ONE_RESET_BIT_BIT          25
`define PSRC_COMPARATOR_ZERO_RESET_BIT_BIT          24
`define PSRC_GP_COUNTER_TWO_RESET_BIT_BIT         18
`define PSRC_GP_COUNTER_ONE_RESET_BIT_BIT         17
`define PSRC_GP_COUNTER_ZERO_RESET_BIT_BIT         16
`define PSRC_SYNC_SERIAL_ZERO_RESET_BIT_BIT           4
`define PSRC_ASYNC_SERIAL_ZERO_RESET_BIT_BIT          0
`define PSRC_GROUP0_RW_MASK     32'h00100008
`define PSRC_GROUP1_RW_MASK     32'h07070011
`endif

// File: design/psrc_reset_fanout.sv
// Turns reset control bits into per-peripheral reset levels
`timescale 1ns/1ps
module psrc_reset_fanout
    import psrc_pkg::*;
(
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire psrc_pkg::psrc_word_t group0,
    input  wire psrc_pkg::psrc_word_t group1,
    output logic [9:0]                periph_reset
);
`include "psrc_regs.svh"
    typedef struct packed {
        logic [9:0] rst;
    } psrc_fan_s;

    psrc_fan_s state;
    psrc_fan_s next_state;

    // Registered so peripherals see a glitch-free reset level
    always_comb
    begin
        next_state.rst = {group0[`PSRC_PWM_BIT], group0[`PSRC_WATCHDOG_BIT],
                          group1[`PSRC_COMPARATOR_TWO_RESET_BIT_BIT], group1[`PSRC_COMPARATOR_ONE_RESET_BIT_BIT], group1[`PSRC_COMPARATOR_ZERO_RESET_BIT_BIT],
                          group1[`PSRC_GP_COUNTER_TWO_RESET_BIT_BIT], group1[`PSRC_GP_COUNTER_ONE_RESET_BIT_BIT], group1[`PSRC_GP_COUNTER_ZERO_RESET_BIT_BIT],
                          group1[`PSRC_SYNC_SERIAL_ZERO_RESET_BIT_BIT], group1[`PSRC_ASYNC_SERIAL_ZERO_RESET_BIT_BIT]};
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state <= '{rst: 10'h000};
        else
            state <= next_state;
    end

    assign periph_reset = state.rst;
endmodule // psrc_reset_fanout

// File: design/psrc_top.sv
// Peripheral software reset control with an AHB-Lite register port
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module psrc_top
    import psrc_pkg::*;
#(
    parameter psrc_word_t CAP_ONE_DEFAULT = 32'h00100008,
    parameter psrc_word_t CAP_TWO_DEFAULT = 32'h07070011
)(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             pwm_reset,
    output logic             watchdog_reset_bit,
    output logic             comparator_zero_reset_bit,
    output logic             comparator_one_reset_bit,
    output logic             comparator_two_reset_bit,
    output logic             gp_counter_zero_reset_bit,
    output logic             gp_counter_one_reset_bit,
    output logic             gp_counter_two_reset_bit,
    output logic             sync_serial_zero_reset_bit,
    output logic             async_serial_zero_reset_bit
);
`include "psrc_regs.svh"

    initial
    begin
        if ((CAP_ONE_DEFAULT & ~`PSRC_GROUP0_RW_MASK) != 32'h00000000)
            $error("capability one names bits with no reset control");
        if ((CAP_TWO_DEFAULT & ~`PSRC_GROUP1_RW_MASK) != 32'h00000000)
            $error("capability two names bits with no reset control");
    end

    typedef struct packed {
        logic       wr_pend;
        psrc_sel_e  wr_sel;
        logic       wr_cap1;
        psrc_word_t cap_one;
        psrc_word_t cap_two;
        psrc_word_t rdata;
    } psrc_top_s;

    psrc_top_s  state;
    psrc_top_s  next_state;
    psrc_word_t group0;
    psrc_word_t group1;
    logic [9:0] periph_reset;
    logic       wr_g0;
    logic       wr_g1;
    logic       addr_ok;
    psrc_sel_e  addr_sel;
    logic       addr_cap1;

    // Decode a word address into the register it selects
    function automatic psrc_sel_e decode(input logic [11:0] a);
        case (a)
            `PSRC_GROUP0_OFFSET:  decode = PSRC_SEL_GROUP0;
            `PSRC_GROUP1_OFFSET:  decode = PSRC_SEL_GROUP1;
            `PSRC_CAP_ONE_OFFSET: decode = PSRC_SEL_CAP;
            `PSRC_CAP_TWO_OFFSET: decode = PSRC_SEL_CAP;
            default:              decode = PSRC_SEL_NONE;
        endcase
    endfunction

    assign addr_ok   = hsel && hready && htrans[1];
    assign addr_sel  = decode(haddr);
    assign addr_cap1 = (haddr == `PSRC_CAP_ONE_OFFSET);

    // Writes land at the end of the data phase, so a read whose address phase overlaps it sees the old data
    assign wr_g0 = state.wr_pend && (state.wr_sel == PSRC_SEL_GROUP0);
    assign wr_g1 = state.wr_pend && (state.wr_sel == PSRC_SEL_GROUP1);

    always_comb
    begin
        next_state = state;
        next_state.wr_pend = 1'b0;
        if (state.wr_pend && state.wr_sel == PSRC_SEL_CAP)
        begin
            // Capability words are writable here so one netlist covers derivatives
            if (state.wr_cap1)
                next_state.cap_one = hwdata & `PSRC_GROUP0_RW_MASK;
            else
                next_state.cap_two = hwdata & `PSRC_GROUP1_RW_MASK;
        end
        if (addr_ok)
        begin
            next_state.wr_pend = hwrite;
            next_state.wr_sel  = addr_sel;
            next_state.wr_cap1 = addr_cap1;
            if (!hwrite)
            begin
                case (addr_sel)
                    PSRC_SEL_GROUP0: next_state.rdata = group0;
                    PSRC_SEL_GROUP1: next_state.rdata = group1;
                    PSRC_SEL_CAP:    next_state.rdata = addr_cap1 ? state.cap_one : state.cap_two;
                    default:         next_state.rdata = 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state <= '{wr_pend: 1'b0, wr_sel: PSRC_SEL_NONE, wr_cap1: 1'b0,
                       cap_one: `PSRC_CAP_ONE_RESET, cap_two: `PSRC_CAP_TWO_RESET, rdata: 32'h00000000};
        else
            state <= next_state;
    end

    assign hrdata    = state.rdata;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    psrc_masked_reg #(
        .RW_MASK (`PSRC_GROUP0_RW_MASK),
        .RST_VAL (`PSRC_GROUP0_RESET)
    ) u_group0 (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .wr_en    (wr_g0),
        .wr_data  (hwdata),
        .cap_mask (state.cap_one),
        .value    (group0)
    );

    psrc_masked_reg #(
        .RW_MASK (`PSRC_GROUP1_RW_MASK),
        .RST_VAL (`PSRC_GROUP1_RESET)
    ) u_group1 (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .wr_en    (wr_g1),
        .wr_data  (hwdata),
        .cap_mask (state.cap_two),
        .value    (group1)
    );

    psrc_reset_fanout u_fanout (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .group0       (group0),
        .group1       (group1),
        .periph_reset (periph_reset)
    );

    assign pwm_reset                   = periph_reset[9];
    assign watchdog_reset_bit          = periph_reset[8];
    assign comparator_two_reset_bit    = periph_reset[7];
    assign comparator_one_reset_bit    = periph_reset[6];
    assign comparator_zero_reset_bit   = periph_reset[5];
    assign gp_counter_two_reset_bit    = periph_reset[4];
    assign gp_counter_one_reset_bit    = periph_reset[3];
    assign gp_counter_zero_reset_bit   = periph_reset[2];
    assign sync_serial_zero_reset_bit  = periph_reset[1];
    assign async_serial_zero_reset_bit = periph_reset[0];

    property p_g0_masked;
        @(posedge hclk) disable iff (!hresetn)
        wr_g0 |=> (group0 == (($past(group0) & ~($past(state.cap_one) & `PSRC_GROUP0_RW_MASK))
                   | ($past(hwdata) & $past(state.cap_one) & `PSRC_GROUP0_RW_MASK)));
    endproperty
    a_g0_masked: assert property (p_g0_masked) else $error("group0 write not masked");

    property p_g1_masked;
        @(posedge hclk) disable iff (!hresetn)
        wr_g1 |=> (group1 == (($past(group1) & ~($past(state.cap_two) & `PSRC_GROUP1_RW_MASK))
                   | ($past(hwdata) & $past(state.cap_two) & `PSRC_GROUP1_RW_MASK)));
    endproperty
    a_g1_masked: assert property (p_g1_masked) else $error("group1 write not masked");

    property p_g0_read;
        @(posedge hclk) disable iff (!hresetn)
        (addr_ok && !hwrite && haddr == `PSRC_GROUP0_OFFSET && !wr_g0) |=> (hrdata == $past(group0));
    endproperty
    a_g0_read: assert property (p_g0_read) else $error("group0 read wrong");

    property p_g1_read;
        @(posedge hclk) disable iff (!hresetn)
        (addr_ok && !hwrite && haddr == `PSRC_GROUP1_OFFSET && !wr_g1) |=> (hrdata == $past(group1));
    endproperty
    a_g1_read: assert property (p_g1_read) else $error("group1 read wrong");

    property p_pwm_out;
        @(posedge hclk) disable iff (!hresetn)
        ##1 (pwm_reset == $past(group0[`PSRC_PWM_BIT]));
    endproperty
    a_pwm_out: assert property (p_pwm_out) else $error("pwm reset not following bit");

    property p_wdt_out;
        @(posedge hclk) disable iff (!hresetn)
        ##1 (watchdog_reset_bit == $past(group0[`PSRC_WATCHDOG_BIT]));
    endproperty
    a_wdt_out: assert property (p_wdt_out) else $error("watchdog reset not following bit");

    property p_comp_out;
        @(posedge hclk) disable iff (!hresetn)
        ##1 ({comparator_two_reset_bit, comparator_one_reset_bit, comparator_zero_reset_bit}
             == $past(group1[26:24]));
    endproperty
    a_comp_out: assert property (p_comp_out) else $error("comparator resets wrong");

    property p_timer_out;
        @(posedge hclk) disable iff (!hresetn)
        ##1 ({gp_counter_two_reset_bit, gp_counter_one_reset_bit, gp_counter_zero_reset_bit}
             == $past(group1[18:16]));
    endproperty
    a_timer_out: assert property (p_timer_out) else $error("timer resets wrong");

    property p_serial_out;
        @(posedge hclk) disable iff (!hresetn)
        ##1 (sync_serial_zero_reset_bit == $past(group1[`PSRC_SYNC_SERIAL_ZERO_RESET_BIT_BIT])
             && async_serial_zero_reset_bit == $past(group1[`PSRC_ASYNC_SERIAL_ZERO_RESET_BIT_BIT]));
    endproperty
    a_serial_out: assert property (p_serial_out) else $error("serial resets wrong");

    property p_reserved_zero;
        @(posedge hclk) disable iff (!hresetn)
        ((group0 & ~`PSRC_GROUP0_RW_MASK) == 32'h00000000)
        && ((group1 & ~`PSRC_GROUP1_RW_MASK) == 32'h00000000);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_hold_release;
        @(posedge hclk) disable iff (!hresetn)
        $fell(group0[`PSRC_WATCHDOG_BIT]) |=> !watchdog_reset_bit;
    endproperty
    a_hold_release: assert property (p_hold_release) else $error("watchdog not released");
endmodule // psrc_top

// File: tb/psrc_tb.sv
// Self-checking bench for the peripheral reset control
`timescale 1ns/1ps
`include "psrc_regs.svh"
module tb;
    import psrc_pkg::*;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    psrc_word_t  hwdata;
    psrc_word_t  hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [9:0]  outs;
    psrc_word_t  rd;
    int          n_errors;
    int          tests_run;
    int          pos [10] = '{`PSRC_PWM_BIT, `PSRC_WATCHDOG_BIT, `PSRC_COMPARATOR_TWO_RESET_BIT_BIT, `PSRC_COMPARATOR_ONE_RESET_BIT_BIT,
                              `PSRC_COMPARATOR_ZERO_RESET_BIT_BIT, `PSRC_GP_COUNTER_TWO_RESET_BIT_BIT, `PSRC_GP_COUNTER_ONE_RESET_BIT_BIT, `PSRC_GP_COUNTER_ZERO_RESET_BIT_BIT,
                              `PSRC_SYNC_SERIAL_ZERO_RESET_BIT_BIT, `PSRC_ASYNC_SERIAL_ZERO_RESET_BIT_BIT};
    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;
    psrc_top i_dut (
        .hclk                       (hclk),
        .hresetn                    (hresetn),
        .hsel                       (hsel),
        .haddr                      (haddr),
        .htrans                     (htrans),
        .hwrite                     (hwrite),
        .hsize                      (hsize),
        .hready                     (hready),
        .hwdata                     (hwdata),
        .hrdata                     (hrdata),
        .hreadyout                  (hreadyout),
        .hresp                      (hresp),
        .pwm_reset                  (outs[9]),
        .watchdog_reset_bit         (outs[8]),
        .comparator_two_reset_bit   (outs[7]),
        .comparator_one_reset_bit   (outs[6]),
        .comparator_zero_reset_bit  (outs[5]),
        .gp_counter_two_reset_bit   (outs[4]),
        .gp_counter_one_reset_bit   (outs[3]),
        .gp_counter_zero_reset_bit  (outs[2]),
        .sync_serial_zero_reset_bit (outs[1]),
        .async_serial_zero_reset_bit(outs[0])
    );
    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    task automatic summarize();
        if (n_errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input psrc_word_t got, input psrc_word_t exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded wait for ready at a rising edge; a hang ends the run
    task automatic wait_ready();
        int k;
        k = 0;
        do
        begin
            @(posedge hclk);
            k++;
        end
        while (hready !== 1'b1 && k < 16);
        if (hready !== 1'b1)
        begin
            n_errors++;
            summarize();
        end
    endtask
    task automatic xfer(input logic [11:0] a, input logic w, input psrc_word_t d, output psrc_word_t r);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= w;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= w ? d : 32'h00000000;
        wait_ready();
        r = hrdata;
        chk({31'h0, hresp}, 32'h00000000);
    endtask
    task automatic wr(input logic [11:0] a, input psrc_word_t d);
        psrc_word_t dummy;
        xfer(a, 1'b1, d, dummy);
    endtask
    task automatic rd_chk(input logic [11:0] a, input psrc_word_t exp);
        xfer(a, 1'b0, 32'h00000000, rd);
        chk(rd, exp);
    endtask
    // Reset levels lag the register by one clock, so settle first
    task automatic out_chk(input logic [9:0] exp);
        repeat (2) @(posedge hclk);
        chk({22'h0, outs}, {22'h0, exp});
    endtask
    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
    endtask
    initial
    begin
        n_errors  = 0;
        tests_run = 0;
        hresetn   = 1'b0;
        hsel      = 1'b0;
        haddr     = 12'h000;
        htrans    = 2'b00;
        hwrite    = 1'b0;
        hsize     = 3'b010;
        hwdata    = 32'h00000000;
        do_reset();
        rd_chk(`PSRC_GROUP0_OFFSET, 32'h00000000);
        rd_chk(`PSRC_GROUP1_OFFSET, 32'h00000000);
        rd_chk(`PSRC_CAP_ONE_OFFSET, 32'h00100008);
        rd_chk(`PSRC_CAP_TWO_OFFSET, 32'h07070011);
        out_chk(10'h000);
        // One control bit at a time catches swapped or misplaced fields
        for (int i = 0; i < 10; i++)
        begin
            wr(i < 2 ? `PSRC_GROUP0_OFFSET : `PSRC_GROUP1_OFFSET, 32'h00000001 << pos[i]);
            rd_chk(i < 2 ? `PSRC_GROUP0_OFFSET : `PSRC_GROUP1_OFFSET, 32'h00000001 << pos[i]);
            out_chk(10'h200 >> i);
            wr(i < 2 ? `PSRC_GROUP0_OFFSET : `PSRC_GROUP1_OFFSET, 32'h00000000);
        end
        wr(`PSRC_GROUP0_OFFSET, 32'hFFFFFFFF);
        rd_chk(`PSRC_GROUP0_OFFSET, 32'h00100008);
        wr(`PSRC_GROUP1_OFFSET, 32'hFFFFFFFF);
        rd_chk(`PSRC_GROUP1_OFFSET, 32'h07070011);
        out_chk(10'h3FF);
        // Drop the PWM capability: its control bit must freeze at 1
        wr(`PSRC_CAP_ONE_OFFSET, 32'h00000008);
        xfer(`PSRC_GROUP0_OFFSET, 1'b0, 32'h00000000, rd);
        wr(`PSRC_GROUP0_OFFSET, rd & ~32'h00100008);
        rd_chk(`PSRC_GROUP0_OFFSET, 32'h00100000);
        out_chk(10'h2FF);
        wr(`PSRC_CAP_ONE_OFFSET, 32'h00100008);
        wr(`PSRC_GROUP0_OFFSET, 32'h00000000);
        rd_chk(`PSRC_GROUP0_OFFSET, 32'h00000000);
        // Comparators only lose capability in the second group
        wr(`PSRC_CAP_TWO_OFFSET, 32'h00070011);
        wr(`PSRC_GROUP1_OFFSET, 32'h00000000);
        rd_chk(`PSRC_GROUP1_OFFSET, 32'h07000000);
        out_chk(10'h0E0);
        wr(`PSRC_CAP_TWO_OFFSET, 32'h07070011);
        wr(`PSRC_GROUP1_OFFSET, 32'h00010010);
        rd_chk(`PSRC_GROUP1_OFFSET, 32'h00010010);
        rd_chk(12'h0FC, 32'h00000000);
        // Reset in mid-run clears both groups and all reset levels
        wr(`PSRC_GROUP0_OFFSET, 32'h00000008);
        do_reset();
        rd_chk(`PSRC_GROUP0_OFFSET, 32'h00000000);
        rd_chk(`PSRC_GROUP1_OFFSET, 32'h00000000);
        out_chk(10'h000);
        summarize();
    end
endmodule // tb
